// >>> rtl/owi_slave.sv
// Two-wire slave with wiper register and one-time fuse command
// Function
// [RL1] Unfused power-up loads midscale wiper code
// [RL2] Address byte: fixed six bits, select, direction
// [RL3] Compare address select bit with pin
// [RL4] Direction zero writes, one reads
// [RL5] Only matching device acknowledges ninth pulse
// [RL6] Instruction byte top bit requests programming
// [RL7] Programming bit one blows the fuses
// [RL8] Data byte low six bits form code
// [RL9] Read sends validation bits plus wiper code
// [RL10] Validation bits 00 ready, 11 programmed
// [RL11] Each byte is eight bits plus acknowledge
// [RL12] Data changes only while clock is low
// [RL13] Master opens transfers with start condition
// [RL14] Master closes transfers with stop condition
// [RL15] Read ends with master not-acknowledge
// [RL16] Write ends with stop at tenth pulse
// [RL17] Every further data byte updates the wiper; the code skips a data byte that ends while the fuse bank is busy
// [RL18] Programmed device ignores written wiper data
// [RL19] New instruction needs a fresh transaction
// [RL20] Reads repeat with identical content
// [RL21] Mismatched device releases line until start
// [RL22] Fused device restores fused code at power-up
`timescale 1ns/10ps
`default_nettype none
module owi_slave #(
   parameter int BLOW_CYCLES = owi_pkg::FUSE_CYCLES
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic address_select_bit_in,
   output logic [5:0] wiper_register_out,
   output logic programmed_out
);
   // ************************************************************
   // Pin synchronisers and edge detection
   // ************************************************************
   logic scl_s, sda_s, sel_s, scl_d, sda_d;
   owi_sync u_sync_scl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .d_in(scl_in), .q_out(scl_s));
   owi_sync u_sync_sda (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .d_in(sda_in), .q_out(sda_s));
   owi_sync u_sync_sel (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .d_in(address_select_bit_in), .q_out(sel_s));
   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   // [RL13] start detection
   assign start_ev = scl_s && scl_d && sda_d && !sda_s;
   // [RL14] stop detection
   assign stop_ev = scl_s && scl_d && !sda_d && sda_s;
   // ************************************************************
   // Fuse bank
   // ************************************************************
   logic blown, fuse_busy, blow_req, next_blow_req;
   logic [5:0] fused;
   owi_fuse #(.BLOW_CYCLES(BLOW_CYCLES)) u_fuse (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .blow_in(blow_req),
      .code_in(wiper_register_out),
      .blown_out(blown),
      .busy_out(fuse_busy),
      .fused_out(fused)
   );
   // ************************************************************
   // Byte engine
   // ************************************************************
   typedef enum {ST_IDLE, ST_ADDR, ST_INSTR, ST_DATA, ST_READ, ST_ACK} owi_state_e;
   typedef enum {PH_ADDR, PH_INSTR, PH_DATA, PH_READ} owi_phase_e;
   owi_state_e state, next_state;
   owi_phase_e phase, next_phase;
   logic [7:0] shreg, next_shreg;
   logic [3:0] bitcnt, next_bitcnt;
   logic ack_drv, next_ack_drv, rd_mode, next_rd_mode, prog_bit, next_prog_bit;
   logic [5:0] next_wiper;
   logic init_done, next_init_done, next_programmed;
   logic next_sda_oe;
   logic [7:0] rd_byte;
   logic [1:0] check_bits;
   // [RL10] validation bits follow fuse status
   assign check_bits = blown ? owi_pkg::CHECK_DONE : owi_pkg::CHECK_READY;
   // [RL9] read byte is check bits then code
   assign rd_byte = {check_bits, wiper_register_out};
   // Next-state logic of the serial engine
   always_comb begin
      next_state = state;
      next_phase = phase;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_ack_drv = ack_drv;
      next_rd_mode = rd_mode;
      next_prog_bit = prog_bit;
      next_wiper = wiper_register_out;
      next_blow_req = 1'b0;
      next_init_done = 1'b1;
      next_programmed = blown;
      next_sda_oe = sda_oe_out;
      // [RL1] midscale when unfused at power-up
      // [RL22] fused code at power-up
      if (!init_done) begin
         next_wiper = blown ? fused : owi_pkg::WIPER_MIDSCALE;
      end
      if (stop_ev) begin
         next_state = ST_IDLE;
         next_sda_oe = 1'b0;
      end else if (start_ev) begin
         next_state = ST_ADDR;
         next_phase = PH_ADDR;
         next_bitcnt = 4'h0;
         next_sda_oe = 1'b0;
      end else begin
         unique case (state)
            // [RL21] idle keeps line released until start
            ST_IDLE: begin
               next_sda_oe = 1'b0;
            end
            ST_ADDR, ST_INSTR, ST_DATA: begin
               // [RL11] shift eight bits msb first on rise
               // [RL12] sample only on clock rise
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], sda_s};
                  next_bitcnt = bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == 4'h8) begin
                  next_bitcnt = 4'h0;
                  next_state = ST_ACK;
                  next_ack_drv = 1'b1;
                  next_sda_oe = 1'b1;
                  if (state == ST_ADDR) begin
                     // [RL2] fixed address and select bit
                     // [RL3] compare select bit with pin
                     // [RL5] acknowledge only on match
                     if (shreg[7:2] != owi_pkg::SLAVE_ADDR ||
                         shreg[owi_pkg::ADDR_SEL_POS] != sel_s) begin
                        next_state = ST_IDLE;
                        next_ack_drv = 1'b0;
                        next_sda_oe = 1'b0;
                     end
                     // [RL4] direction bit selects read
                     next_rd_mode = shreg[owi_pkg::DIR_POS];
                  end else if (state == ST_INSTR) begin
                     // [RL6] keep top bit, ignore the rest
                     next_prog_bit = shreg[owi_pkg::PROG_BIT_POS];
                  end else begin
                     // [RL8] low six bits form new code
                     // [RL17] every data byte updates unless the fuse bank is busy
                     // [RL18] ignored once fused
                     if (!blown && !fuse_busy) begin
                        next_wiper = shreg[5:0];
                     end
                     // [RL7] programming bit blows fuses
                     if (prog_bit && !blown) begin
                        next_blow_req = 1'b1;
                     end
                  end
               end
            end
            ST_ACK: begin
               // Release ack after ninth pulse falls
               if (scl_fall) begin
                  next_ack_drv = 1'b0;
                  next_sda_oe = 1'b0;
                  unique case (phase)
                     PH_ADDR: begin
                        if (rd_mode) begin
                           // [RL9] read byte right after address ack
                           // [RL20] read copies state, changes nothing
                           next_state = ST_READ;
                           next_phase = PH_READ;
                           next_shreg = rd_byte;
                           next_sda_oe = !rd_byte[7];
                        end else begin
                           next_state = ST_INSTR;
                           next_phase = PH_INSTR;
                        end
                     end
                     PH_INSTR, PH_DATA: begin
                        next_state = ST_DATA;
                        next_phase = PH_DATA;
                     end
                     PH_READ: begin
                        // [RL15] ninth pulse fall ends the read, whether master acks or nacks
                        next_state = ST_IDLE;
                     end
                  endcase
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  next_bitcnt = bitcnt + 4'h1;
                  if (bitcnt == 4'h7) begin
                     next_state = ST_ACK;
                     next_sda_oe = 1'b0;
                     next_bitcnt = 4'h0;
                  end else begin
                     next_shreg = {shreg[6:0], 1'b0};
                     next_sda_oe = !shreg[6];
                  end
               end
            end
         endcase
      end
   end
   // Registers of the serial engine
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         state <= ST_IDLE;
         phase <= PH_ADDR;
         shreg <= 8'h00;
         bitcnt <= 4'h0;
         ack_drv <= 1'b0;
         rd_mode <= 1'b0;
         prog_bit <= 1'b0;
         wiper_register_out <= owi_pkg::WIPER_MIDSCALE;
         blow_req <= 1'b0;
         init_done <= 1'b0;
         programmed_out <= 1'b0;
         sda_oe_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         state <= next_state;
         phase <= next_phase;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         ack_drv <= next_ack_drv;
         rd_mode <= next_rd_mode;
         prog_bit <= next_prog_bit;
         wiper_register_out <= next_wiper;
         blow_req <= next_blow_req;
         init_done <= next_init_done;
         programmed_out <= next_programmed;
         sda_oe_out <= next_sda_oe;
         sda_out <= 1'b0;
      end
   end
   // ************************************************************
   // Assertions
   // ************************************************************
   a_no_drive_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL21]
      (state == ST_IDLE && $past(state) == ST_IDLE) |-> !sda_oe_out)
      else $error("line driven while idle");
   a_fused_wiper_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL18]
      (blown && init_done && $past(init_done) && $past(blown)) |-> $stable(wiper_register_out))
      else $error("wiper changed after fusing");
   a_check_bits_done: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL10]
      blown |-> rd_byte[7:6] == 2'h3)
      else $error("validation bits wrong");
   a_blow_on_prog: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL7]
      blow_req |-> ##1 (fuse_busy || blown))
      else $error("fuse not started");
   a_output_low: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL5]
      sda_oe_out |-> !sda_out)
      else $error("line driven high");
   a_stop_release: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL14]
      stop_ev |=> (state == ST_IDLE && !sda_oe_out))
      else $error("stop not obeyed");
   a_start_addr: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL13]
      (start_ev && !stop_ev) |=> (state == ST_ADDR && bitcnt == 4'h0))
      else $error("start not obeyed");
   a_init_mid: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL1]
      (!init_done && !blown) |=> wiper_register_out == owi_pkg::WIPER_MIDSCALE)
      else $error("not midscale at power-up");
   c_ack: cover property (@(posedge clk_in) state == ST_ACK && ack_drv);
   c_read: cover property (@(posedge clk_in) state == ST_READ);
   c_blow: cover property (@(posedge clk_in) blow_req);
   c_mismatch: cover property (@(posedge clk_in)
      state == ST_ADDR && scl_fall && bitcnt == 4'h8 && shreg[owi_pkg::ADDR_SEL_POS] != sel_s);
   c_fused_read: cover property (@(posedge clk_in) state == ST_READ && blown);
   // ************************************************************
   // Data path and framing checks
   // ************************************************************
   // Address select mismatch drops the device off the bus
   a_select_mismatch: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL3]
      (state == ST_ADDR && scl_fall && bitcnt == 4'h8 &&
       shreg[owi_pkg::ADDR_SEL_POS] != sel_s) |=> (state == ST_IDLE && !sda_oe_out))
      else $error("select mismatch answered");
   // Acknowledge slot pulls the line low
   a_ack_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL5]
      (state == ST_ACK && ack_drv) |-> sda_oe_out)
      else $error("acknowledge not driven");
   // Instruction top bit is kept for the data bytes
   a_prog_latch: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL6]
      (state == ST_INSTR && scl_fall && bitcnt == 4'h8) |=>
      ({7'h00, prog_bit} == ($past(shreg) >> owi_pkg::PROG_BIT_POS)))
      else $error("programming bit not latched");
   // Each data byte loads its low six bits while unfused and the fuse bank is not busy
   a_wiper_load: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL8]
      (state == ST_DATA && scl_fall && bitcnt == 4'h8 && !blown && !fuse_busy) |=>
      ({2'h0, wiper_register_out} == ($past(shreg) & 8'h3F)))
      else $error("wiper not loaded from data");
   // Fuse bank captures the code that stands at the blow request
   a_fuse_code: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL7]
      blow_req |=> (fused == $past(wiper_register_out)))
      else $error("fused code differs from wiper");
   // Read engine loads the status and code byte after the address ack
   a_read_load: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RL9]
      (state == ST_ACK && phase == PH_ADDR && rd_mode && scl_fall) |=>
      (state == ST_READ && shreg == $past(rd_byte)))
      else $error("read byte not loaded");
endmodule : owi_slave
`default_nettype wire

// >>> include/owi_pkg.sv
// Package of constants for the one-time-fuse wiper two-wire slave
package owi_pkg;
   // ************************************************************
   // Bus address and field layout
   // ************************************************************
   localparam logic [5:0] SLAVE_ADDR = 6'h16;
   localparam int ADDR_SEL_POS = 1;
   localparam int DIR_POS = 0;
   localparam int PROG_BIT_POS = 7;
   localparam int WIPER_W = 6;
   // ************************************************************
   // Reset values and validation codes
   // ************************************************************
   localparam logic [5:0] WIPER_MIDSCALE = 6'h20;
   localparam logic [1:0] CHECK_READY = 2'h0;
   localparam logic [1:0] CHECK_DONE = 2'h3;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int SYNC_STAGES = 2;
   localparam int FUSE_TIME_NS = 400;
   localparam int CLK_PERIOD_NS = 10;
   localparam int FUSE_CYCLES = (FUSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : owi_pkg

// >>> rtl/owi_sync.sv
// Two-flop synchroniser for one pin input
`timescale 1ns/10ps
`default_nettype none
module owi_sync (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta;
   // Two stages; first stage read only by the second
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         meta <= 1'b1;
         q_out <= 1'b1;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule : owi_sync
`default_nettype wire

// >>> rtl/owi_fuse.sv
// Fuse bank model: holds the fused wiper code and the blown flag
`timescale 1ns/10ps
`default_nettype none
module owi_fuse #(
   parameter int BLOW_CYCLES = owi_pkg::FUSE_CYCLES
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic blow_in,
   input wire logic [5:0] code_in,
   output logic blown_out,
   output logic busy_out,
   output logic [5:0] fused_out
);
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic next_blown;
   logic next_busy;
   logic [5:0] next_fused;
   // Fuse cells start unblown at power-on; reset never clears them
   logic blown = 1'b0;
   logic [5:0] fused = 6'h00;
   assign blown_out = blown;
   assign fused_out = fused;
   // Fuses model non-volatile state, so reset leaves them as is
   always_comb begin
      next_cnt = cnt;
      next_blown = blown;
      next_busy = busy_out;
      next_fused = fused;
      if (blow_in && !blown && !busy_out) begin
         next_busy = 1'b1;
         next_fused = code_in;
         next_cnt = 16'h0000;
      end else if (busy_out) begin
         next_cnt = cnt + 16'h0001;
         if (cnt == 16'(BLOW_CYCLES - 1)) begin
            next_busy = 1'b0;
            next_blown = 1'b1;
         end
      end
   end
   // Registers of the fuse bank
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt <= 16'h0000;
         busy_out <= 1'b0;
      end else begin
         cnt <= next_cnt;
         busy_out <= next_busy;
      end
   end
   // Fuse state survives power-up reset
   always_ff @(posedge clk_in) begin
      blown <= next_blown;
      fused <= next_fused;
   end
endmodule : owi_fuse
`default_nettype wire

// >>> verification/owi_master_model.sv
// Two-wire bus master model that drives the serial clock and data lines
`timescale 1ns/10ps
`default_nettype none
module owi_master_model (
   output logic scl_out,
   output logic sda_low_out,
   input wire logic sda_in
);
   localparam realtime QTR = 31.25;
   // Bus idles released, clock stands high between frames
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // ************************************************************
   // Framing
   // ************************************************************
   // data falls while clock high
   task automatic bus_start();
      #(2*QTR) sda_low_out <= 1'b1;
      #(2*QTR) scl_out <= 1'b0;
   endtask : bus_start
   // data rises while clock high on the tenth pulse
   task automatic bus_stop();
      #QTR sda_low_out <= 1'b1;
      #QTR scl_out <= 1'b1;
      #(2*QTR) sda_low_out <= 1'b0;
      #(4*QTR);
   endtask : bus_stop
   // ************************************************************
   // Bits and bytes
   // ************************************************************
   // data set mid low phase, sampled at end of high phase
   task automatic bit_cycle(input logic drive_low, output logic seen);
      #QTR sda_low_out <= drive_low;
      #QTR scl_out <= 1'b1;
      #(2*QTR) seen = sda_in;
      scl_out <= 1'b0;
   endtask : bit_cycle
   // eight bits most significant first, then the acknowledge slot
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(~b[i], s);
      end
      bit_cycle(1'b0, s);
      ack = ~s;
   endtask : put_byte
   // line released for the byte and left high as not-acknowledge
   task automatic get_byte(output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b0, s);
         b[i] = s;
      end
      bit_cycle(1'b0, s);
   endtask : get_byte
endmodule : owi_master_model
`default_nettype wire

// >>> verification/test_otp_wiper_i2c_slave.sv
// Self-checking bench for the one-time-fuse wiper two-wire slave
`timescale 1ns/10ps
`default_nettype none
module test_otp_wiper_i2c_slave;
   localparam int BLOW = 4;
   typedef struct packed {
      logic pin;
      logic sel;
      logic [7:0] data;
      logic ack;
      logic [5:0] exp;
   } owi_row_s;
   owi_row_s rows [5] = '{'{1'b0, 1'b0, 8'h3F, 1'b1, 6'h3F}, '{1'b1, 1'b1, 8'hC0, 1'b1, 6'h00},
      '{1'b1, 1'b0, 8'h2A, 1'b0, 6'h00}, '{1'b0, 1'b1, 8'h15, 1'b0, 6'h00},
      '{1'b0, 1'b0, 8'hD5, 1'b1, 6'h15}};
   logic clk_in, sys_rst_in, pin_sel, scl, sda_low, sda_out, sda_oe, programmed, ack, oe_q;
   logic [5:0] wiper;
   logic [7:0] rd;
   wire logic sda_line;
   int errors, checks, cycles;
   // Wired line with pull-up: low when either party pulls it
   assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
   owi_slave #(.BLOW_CYCLES(BLOW)) owi_slave_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe),
      .address_select_bit_in(pin_sel), .wiper_register_out(wiper), .programmed_out(programmed));
   owi_master_model owi_master_model_i (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_line));
   // ************************************************************
   // Checking and closing
   // ************************************************************
   task automatic check_bit(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask : check_bit
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check_byte
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // ************************************************************
   // Transactions and reset
   // ************************************************************
   task automatic wr(input logic sel, input logic [7:0] instr, input logic [7:0] data,
         output logic a);
      logic d;
      owi_master_model_i.bus_start();
      owi_master_model_i.put_byte({owi_pkg::SLAVE_ADDR, sel, 1'b0}, a);
      owi_master_model_i.put_byte(instr, d);
      owi_master_model_i.put_byte(data, d);
      owi_master_model_i.bus_stop();
   endtask : wr
   task automatic rd_xfer(input logic sel, output logic a, output logic [7:0] b);
      owi_master_model_i.bus_start();
      owi_master_model_i.put_byte({owi_pkg::SLAVE_ADDR, sel, 1'b1}, a);
      owi_master_model_i.get_byte(b);
      owi_master_model_i.bus_stop();
   endtask : rd_xfer
   task automatic apply_reset();
      @(negedge clk_in);
      sys_rst_in = 1'b1;
      repeat (4) @(negedge clk_in);
      sys_rst_in = 1'b0;
      repeat (6) @(negedge clk_in);
   endtask : apply_reset
   // Clock, hang limit and data-line stability monitor
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         $display("CHECK FAILED %0t timeout", $time);
         print_verdict();
      end
   end
   always @(negedge clk_in) begin
      if (cycles > 2 && sda_oe !== oe_q && scl === 1'b1) begin
         check_bit(1'b0, 1'b1, "data moved, clock high");
      end
      oe_q <= sda_oe;
   end
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      sys_rst_in = 1'b1;
      pin_sel = 1'b0;
      oe_q = 1'b0;
      errors = 0;
      checks = 0;
      cycles = 0;
      apply_reset();
      check_byte({2'h0, wiper}, {2'h0, owi_pkg::WIPER_MIDSCALE}, "power-up wiper");
      rd_xfer(1'b0, ack, rd);
      check_byte(rd, {owi_pkg::CHECK_READY, owi_pkg::WIPER_MIDSCALE}, "ready read");
      // Table of plain writes across select pin and address select bit
      foreach (rows[i]) begin
         @(negedge clk_in);
         pin_sel = rows[i].pin;
         repeat (4) @(negedge clk_in);
         wr(rows[i].sel, 8'h00, rows[i].data, ack);
         check_bit(ack, rows[i].ack, "address ack");
         check_byte({2'h0, wiper}, {2'h0, rows[i].exp}, "written wiper");
      end
      // Repeated data bytes, instruction low bits set
      owi_master_model_i.bus_start();
      owi_master_model_i.put_byte({owi_pkg::SLAVE_ADDR, 2'b00}, ack);
      owi_master_model_i.put_byte(8'h7F, ack);
      owi_master_model_i.put_byte(8'h05, ack);
      check_byte({2'h0, wiper}, 8'h05, "first data byte");
      owi_master_model_i.put_byte(8'h06, ack);
      check_byte({2'h0, wiper}, 8'h06, "second data byte");
      owi_master_model_i.bus_stop();
      check_bit(programmed, 1'b0, "low instruction bits");
      // Wrong fixed address bits: no answer, line left released
      owi_master_model_i.bus_start();
      owi_master_model_i.put_byte({6'h17, 2'b01}, ack);
      check_bit(ack, 1'b0, "foreign address");
      owi_master_model_i.get_byte(rd);
      check_byte(rd, 8'hFF, "released line");
      owi_master_model_i.bus_stop();
      // Back-to-back reads return the same content
      for (int k = 0; k < 2; k++) begin
         rd_xfer(1'b0, ack, rd);
         check_byte(rd, {owi_pkg::CHECK_READY, 6'h06}, "repeated read");
      end
      // Fresh transaction carrying the programming instruction
      wr(1'b0, 8'h80, 8'h2C, ack);
      repeat (BLOW + 10) @(negedge clk_in);
      check_bit(programmed, 1'b1, "fuse blown");
      rd_xfer(1'b0, ack, rd);
      check_byte(rd, {owi_pkg::CHECK_DONE, 6'h2C}, "programmed read");
      wr(1'b0, 8'h00, 8'h01, ack);
      check_byte({2'h0, wiper}, 8'h2C, "write after fuse");
      apply_reset();
      check_byte({2'h0, wiper}, 8'h2C, "fused power-up");
      check_bit(programmed, 1'b1, "fuse survives reset");
      print_verdict();
   end
endmodule : test_otp_wiper_i2c_slave
`default_nettype wire
